// file: design/rfb_pkg.sv
`default_nettype none
package rfb_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_FRAME = 8'h00;
  localparam logic [7:0] ADDR_AMP = 8'h04;
  localparam logic [7:0] ADDR_TIMER = 8'h08;
  localparam logic [7:0] ADDR_EXTERNAL_SIGNAL_OUTPUT_PIN = 8'h0c;
  localparam logic [7:0] ADDR_DRV = 8'h10;
  localparam logic [7:0] ADDR_RXCTL = 8'h14;
  localparam logic [7:0] ADDR_TXDATA = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_RCV = 8'h38;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam int CNT_W = 5;

  typedef struct packed {
    logic [3:0] skip;
    logic [2:0] guard;
    logic stop_val;
    logic par_odd;
    logic par_en;
    logic start_val;
    logic start_en;
    logic [3:0] coder;
  } rfb_frame_cfg_s;

  typedef struct packed {
    logic os_en;
    logic [4:0] cw;
    logic [4:0] resid;
  } rfb_amp_cfg_s;

  typedef struct packed {
    logic [7:0] bit_period;
    logic [7:0] t2;
    logic [7:0] t1;
  } rfb_timer_cfg_s;

  typedef struct packed {
    logic [1:0] in_sel;
    logic bypass;
    logic single;
  } rfb_rcv_cfg_s;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } rfb_tx_word_s;

  localparam rfb_frame_cfg_s FRAME_RESET = 16'h0000;
  localparam rfb_amp_cfg_s AMP_RESET = 11'h000;
  localparam rfb_timer_cfg_s TIMER_RESET = 24'h000000;
  localparam rfb_rcv_cfg_s RCV_RESET = 4'h0;

  localparam logic [3:0] CODER_DEFAULT = 4'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] EXTERNAL_SIGNAL_OUTPUT_PIN_LOW = 4'h0;
  localparam logic [3:0] EXTERNAL_SIGNAL_OUTPUT_PIN_HIGH = 4'h1;
  localparam logic [3:0] EXTERNAL_SIGNAL_OUTPUT_PIN_ENVELOPE = 4'h4;
  localparam logic [3:0] EXTERNAL_SIGNAL_OUTPUT_PIN_CODE = 4'h6;
  localparam logic [1:0] EXTERNAL_SIGNAL_INPUT_PIN_INTERNAL = 2'h0;
  localparam logic [1:0] EXTERNAL_SIGNAL_INPUT_PIN_SUBCARRIER = 2'h1;
  localparam logic [1:0] EXTERNAL_SIGNAL_INPUT_PIN_GENERIC = 2'h3;
  localparam logic [1:0] DRV_LOW = 2'h0;
  localparam logic [1:0] DRV_INTERNAL = 2'h1;
  localparam logic [1:0] DRV_EXTERNAL = 2'h2;

  // residual carrier percent per setting
  localparam logic [6:0] RESID_PCT [0:31] = '{
    7'h63, 7'h62, 7'h60, 7'h5e, 7'h5b, 7'h59, 7'h57, 7'h56,
    7'h55, 7'h54, 7'h53, 7'h52, 7'h51, 7'h50, 7'h4f, 7'h4e,
    7'h4d, 7'h4c, 7'h4b, 7'h4a, 7'h48, 7'h46, 7'h44, 7'h41,
    7'h3c, 7'h37, 7'h32, 7'h2d, 7'h28, 7'h23, 7'h1e, 7'h19};

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP, ST_GUARD
  } rfb_bit_state_e;

  typedef enum logic [1:0] {OS_OFF, OS_T1, OS_T2} rfb_os_state_e;
endpackage
`default_nettype wire

// file: design/rfb_framer.sv
// Contract
// - residual settings 25..31 give 55 down to 25 percent residual carrier.
// - overshoot protection for full keying uses two programmable timers.
// - first timer drives carrier level, then residual level for second timer.
// - bit generator active only at coder type 0000, works byte by byte.
// - optional start bit of configured value before every byte.
// - stop bit plus up to six whole guard bits after each byte; the 3-bit guard field accepts up to seven.
// - optional parity bit of configured type in each byte.
// - final byte of a frame drops the programmed count of trailing bits.
// - data bytes go out least significant bit first.
// - single-ended bit low selects fully differential receive inputs.
// - single-ended bit high selects quasi differential, board ties inputs.
// - converter bypass bit at 38h wires mixers straight to the converter.
// - signal output select 4 routes the coder envelope to the output pin.
// - signal input select 1 takes subcarrier manchester from the input pin.
// - passive and active antennas are driven one after the other only; code enforces this for driver source DRV_INTERNAL only.
`timescale 1ns/10ps
`default_nettype none
module rfb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign count = count_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule // rfb_fifo

module rfb_framer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_signal_input_pin,
  input wire logic rx_demod_code,
  output logic external_signal_output_pin,
  output logic driver_envelope,
  output logic [4:0] driver_amplitude,
  output logic [6:0] residual_level_pct,
  output logic rx_single_ended,
  output logic mixer_bypass_to_converter,
  output logic decoder_input,
  output logic decoder_subcarrier,
  output logic multiple_frame_receive,
  output logic tx_busy
);
  rfb_pkg::rfb_frame_cfg_s frame_reg;
  rfb_pkg::rfb_amp_cfg_s amp_reg;
  rfb_pkg::rfb_timer_cfg_s timer_reg;
  rfb_pkg::rfb_rcv_cfg_s rcv_reg;
  logic [3:0] signal_output_select_reg;
  logic [1:0] driver_source_select_reg;
  logic multiple_frame_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic setup;
  logic access;
  logic wr_ok;
  logic data_wr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  rfb_pkg::rfb_tx_word_s fifo_out;
  logic [rfb_pkg::CNT_W-1:0] fifo_count;

  // both pins cross from the analog side
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic external_signal_input_pin_s;
  logic demod_s;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign data_wr = access && pwrite && (paddr == rfb_pkg::ADDR_TXDATA);
  // full fifo stalls the bus write rather than dropping the byte
  assign pready = !(data_wr && !fifo_in_ready);
  assign wr_ok = access && pwrite && pready;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && access;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_reg <= rfb_pkg::FRAME_RESET;
      amp_reg <= rfb_pkg::AMP_RESET;
      timer_reg <= rfb_pkg::TIMER_RESET;
      rcv_reg <= rfb_pkg::RCV_RESET;
      signal_output_select_reg <= rfb_pkg::EXTERNAL_SIGNAL_OUTPUT_PIN_LOW;
      driver_source_select_reg <= rfb_pkg::DRV_LOW;
      multiple_frame_reg <= 1'b0;
    end
    else if (wr_ok)
    begin
      if (paddr == rfb_pkg::ADDR_FRAME)
        frame_reg <= pwdata[$bits(rfb_pkg::rfb_frame_cfg_s)-1:0];
      else if (paddr == rfb_pkg::ADDR_AMP)
        amp_reg <= pwdata[$bits(rfb_pkg::rfb_amp_cfg_s)-1:0];
      else if (paddr == rfb_pkg::ADDR_TIMER)
        timer_reg <= pwdata[$bits(rfb_pkg::rfb_timer_cfg_s)-1:0];
      else if (paddr == rfb_pkg::ADDR_EXTERNAL_SIGNAL_OUTPUT_PIN)
        signal_output_select_reg <= pwdata[3:0];
      else if (paddr == rfb_pkg::ADDR_DRV)
        driver_source_select_reg <= pwdata[1:0];
      else if (paddr == rfb_pkg::ADDR_RXCTL)
        multiple_frame_reg <= pwdata[0];
      else if (paddr == rfb_pkg::ADDR_RCV)
        rcv_reg <= pwdata[$bits(rfb_pkg::rfb_rcv_cfg_s)-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      if (paddr == rfb_pkg::ADDR_FRAME)
        prdata_reg <= {16'h0000, frame_reg};
      else if (paddr == rfb_pkg::ADDR_AMP)
        prdata_reg <= {21'h000000, amp_reg};
      else if (paddr == rfb_pkg::ADDR_TIMER)
        prdata_reg <= {8'h00, timer_reg};
      else if (paddr == rfb_pkg::ADDR_EXTERNAL_SIGNAL_OUTPUT_PIN)
        prdata_reg <= {28'h0000000, signal_output_select_reg};
      else if (paddr == rfb_pkg::ADDR_DRV)
        prdata_reg <= {30'h00000000, driver_source_select_reg};
      else if (paddr == rfb_pkg::ADDR_RXCTL)
        prdata_reg <= {31'h00000000, multiple_frame_reg};
      else if (paddr == rfb_pkg::ADDR_TXDATA)
        prdata_reg <= 32'h00000000;
      else if (paddr == rfb_pkg::ADDR_STATUS)
        prdata_reg <= {26'h0000000, tx_busy, fifo_count};
      else if (paddr == rfb_pkg::ADDR_RCV)
        prdata_reg <= {28'h0000000, rcv_reg};
      else
        pslverr_reg <= 1'b1;
    end
  end

  rfb_fifo #(
    .WIDTH(rfb_pkg::FIFO_WIDTH),
    .DEPTH(rfb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(data_wr),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[rfb_pkg::FIFO_WIDTH-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out),
    .count(fifo_count)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end
    else
    begin
      sync1_reg <= {rx_demod_code, external_signal_input_pin};
      sync2_reg <= sync1_reg;
    end
  end
  assign external_signal_input_pin_s = sync2_reg[0];
  assign demod_s = sync2_reg[1];

  // bit generator
  rfb_pkg::rfb_bit_state_e st_reg;
  rfb_pkg::rfb_bit_state_e st_first;
  logic [7:0] shift_reg;
  logic [3:0] dcnt_reg;
  logic [2:0] gcnt_reg;
  logic [7:0] bcnt_reg;
  logic par_reg;
  logic tick;
  logic [3:0] nbits;
  logic coder_env;
  logic gen_on;

  assign gen_on = (frame_reg.coder == rfb_pkg::CODER_DEFAULT);
  assign fifo_out_ready = gen_on && (st_reg == rfb_pkg::ST_IDLE);
  assign tick = (bcnt_reg == timer_reg.bit_period);
  assign tx_busy = (st_reg != rfb_pkg::ST_IDLE);

  always_comb
  begin
    nbits = rfb_pkg::BYTE_BITS;
    if (fifo_out.last)
    begin
      if (frame_reg.skip > rfb_pkg::BYTE_BITS)
        nbits = 4'h0;
      else
        nbits = rfb_pkg::BYTE_BITS - frame_reg.skip;
    end
    if (frame_reg.start_en)
      st_first = rfb_pkg::ST_START;
    else if (nbits != 4'h0)
      st_first = rfb_pkg::ST_DATA;
    else if (frame_reg.par_en)
      st_first = rfb_pkg::ST_PARITY;
    else
      st_first = rfb_pkg::ST_STOP;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bcnt_reg <= 8'h00;
    else if (st_reg == rfb_pkg::ST_IDLE || tick)
      bcnt_reg <= 8'h00;
    else
      bcnt_reg <= bcnt_reg + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= rfb_pkg::ST_IDLE;
      shift_reg <= 8'h00;
      dcnt_reg <= 4'h0;
      gcnt_reg <= 3'h0;
      par_reg <= 1'b0;
    end
    else
    begin
      case (st_reg)
        rfb_pkg::ST_IDLE:
          if (fifo_out_valid && fifo_out_ready)
          begin
            shift_reg <= fifo_out.data;
            dcnt_reg <= nbits;
            gcnt_reg <= frame_reg.guard;
            par_reg <= 1'b0;
            st_reg <= st_first;
          end
        rfb_pkg::ST_START:
          if (tick)
          begin
            if (dcnt_reg != 4'h0)
              st_reg <= rfb_pkg::ST_DATA;
            else if (frame_reg.par_en)
              st_reg <= rfb_pkg::ST_PARITY;
            else
              st_reg <= rfb_pkg::ST_STOP;
          end
        rfb_pkg::ST_DATA:
          if (tick)
          begin
            shift_reg <= {1'b0, shift_reg[7:1]};
            par_reg <= par_reg ^ shift_reg[0];
            dcnt_reg <= dcnt_reg - 4'h1;
            if (dcnt_reg == 4'h1)
              st_reg <= frame_reg.par_en ? rfb_pkg::ST_PARITY
                                         : rfb_pkg::ST_STOP;
          end
        rfb_pkg::ST_PARITY:
          if (tick)
            st_reg <= rfb_pkg::ST_STOP;
        rfb_pkg::ST_STOP:
          if (tick)
            st_reg <= (gcnt_reg != 3'h0) ? rfb_pkg::ST_GUARD
                                         : rfb_pkg::ST_IDLE;
        rfb_pkg::ST_GUARD:
          if (tick)
          begin
            gcnt_reg <= gcnt_reg - 3'h1;
            if (gcnt_reg == 3'h1)
              st_reg <= rfb_pkg::ST_IDLE;
          end
        default:
          st_reg <= rfb_pkg::ST_IDLE;
      endcase
    end
  end

  // guard count above six is taken as written; hardware does not clamp
  always_comb
  begin
    case (st_reg)
      rfb_pkg::ST_START: coder_env = frame_reg.start_val;
      rfb_pkg::ST_DATA: coder_env = shift_reg[0];
      rfb_pkg::ST_PARITY: coder_env = par_reg ^ frame_reg.par_odd;
      rfb_pkg::ST_STOP: coder_env = frame_reg.stop_val;
      rfb_pkg::ST_GUARD: coder_env = frame_reg.stop_val;
      default: coder_env = 1'b1;
    endcase
  end

  // routing between coder, decoder and the two antenna paths
  logic active_path;
  logic drv_env;
  logic external_signal_output_pin_next;
  logic dec_next;

  assign active_path =
    (signal_output_select_reg == rfb_pkg::EXTERNAL_SIGNAL_OUTPUT_PIN_ENVELOPE);

  always_comb
  begin
    case (driver_source_select_reg)
      rfb_pkg::DRV_LOW: drv_env = 1'b0;
      // passive path rests while the active antenna is served
      rfb_pkg::DRV_INTERNAL: drv_env = active_path ? 1'b0 : coder_env;
      rfb_pkg::DRV_EXTERNAL: drv_env = external_signal_input_pin_s;
      default: drv_env = 1'b1;
    endcase
    case (signal_output_select_reg)
      rfb_pkg::EXTERNAL_SIGNAL_OUTPUT_PIN_HIGH: external_signal_output_pin_next = 1'b1;
      rfb_pkg::EXTERNAL_SIGNAL_OUTPUT_PIN_ENVELOPE: external_signal_output_pin_next = coder_env;
      rfb_pkg::EXTERNAL_SIGNAL_OUTPUT_PIN_CODE: external_signal_output_pin_next = demod_s;
      default: external_signal_output_pin_next = 1'b0;
    endcase
    case (rcv_reg.in_sel)
      rfb_pkg::EXTERNAL_SIGNAL_INPUT_PIN_SUBCARRIER: dec_next = external_signal_input_pin_s;
      rfb_pkg::EXTERNAL_SIGNAL_INPUT_PIN_GENERIC: dec_next = external_signal_input_pin_s;
      default: dec_next = demod_s;
    endcase
  end

  // overshoot shaping on each carrier restart
  rfb_pkg::rfb_os_state_e os_reg;
  logic [7:0] os_cnt_reg;
  logic env_prev_reg;
  logic os_start;

  // start on the raw edge so the amplitude lines up with the envelope flop
  assign os_start = (os_reg == rfb_pkg::OS_OFF) && amp_reg.os_en
    && drv_env && !env_prev_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      os_reg <= rfb_pkg::OS_OFF;
      os_cnt_reg <= 8'h00;
      env_prev_reg <= 1'b0;
    end
    else
    begin
      env_prev_reg <= drv_env;
      case (os_reg)
        rfb_pkg::OS_OFF:
          if (os_start)
          begin
            os_reg <= rfb_pkg::OS_T1;
            os_cnt_reg <= timer_reg.t1;
          end
        rfb_pkg::OS_T1:
          if (os_cnt_reg == 8'h00)
          begin
            os_reg <= rfb_pkg::OS_T2;
            os_cnt_reg <= timer_reg.t2;
          end
          else
            os_cnt_reg <= os_cnt_reg - 8'h01;
        rfb_pkg::OS_T2:
          if (os_cnt_reg == 8'h00)
            os_reg <= rfb_pkg::OS_OFF;
          else
            os_cnt_reg <= os_cnt_reg - 8'h01;
        default:
          os_reg <= rfb_pkg::OS_OFF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      driver_amplitude <= 5'h00;
      residual_level_pct <= 7'h00;
      driver_envelope <= 1'b0;
      external_signal_output_pin <= 1'b0;
      decoder_input <= 1'b0;
      decoder_subcarrier <= 1'b0;
      rx_single_ended <= 1'b0;
      mixer_bypass_to_converter <= 1'b0;
      multiple_frame_receive <= 1'b0;
    end
    else
    begin
      if (os_start || (os_reg == rfb_pkg::OS_T1 && os_cnt_reg != 8'h00))
        driver_amplitude <= amp_reg.cw;
      else if (os_reg == rfb_pkg::OS_T1
        || (os_reg == rfb_pkg::OS_T2 && os_cnt_reg != 8'h00))
        driver_amplitude <= amp_reg.resid;
      else if (drv_env)
        driver_amplitude <= amp_reg.cw;
      else if (amp_reg.os_en)
        driver_amplitude <= 5'h00;
      else
        driver_amplitude <= amp_reg.resid;
      residual_level_pct <= rfb_pkg::RESID_PCT[amp_reg.resid];
      driver_envelope <= drv_env;
      external_signal_output_pin <= external_signal_output_pin_next;
      decoder_input <= dec_next;
      decoder_subcarrier <=
        (rcv_reg.in_sel == rfb_pkg::EXTERNAL_SIGNAL_INPUT_PIN_SUBCARRIER);
      rx_single_ended <= rcv_reg.single;
      mixer_bypass_to_converter <= rcv_reg.bypass;
      multiple_frame_receive <= multiple_frame_reg;
    end
  end
endmodule // rfb_framer
`default_nettype wire

// file: testbench/rfb_framer_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rfb_framer_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic driver_envelope,
  input wire logic [6:0] residual_level_pct,
  input wire logic rx_single_ended,
  input wire logic mixer_bypass_to_converter,
  input wire logic decoder_subcarrier,
  input wire logic multiple_frame_receive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] resid_w;
  logic [3:0] rcv_w;
  logic [3:0] sig_w;
  logic [1:0] drv_w;
  logic mfr_w;
  logic [3:0] quiet;
  logic wr_acc;
  logic mapped;
  assign wr_acc = psel && penable && pready && pwrite;
  assign mapped = (paddr[1:0] == 2'h0 && paddr < 8'h20)
    || paddr == rfb_pkg::ADDR_RCV;
  // shadows follow accepted writes only, so a stalled push changes nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      resid_w <= 5'h00;
      rcv_w <= 4'h0;
      sig_w <= 4'h0;
      drv_w <= 2'h0;
      mfr_w <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (paddr == rfb_pkg::ADDR_AMP) resid_w <= pwdata[4:0];
      if (paddr == rfb_pkg::ADDR_RCV) rcv_w <= pwdata[3:0];
      if (paddr == rfb_pkg::ADDR_EXTERNAL_SIGNAL_OUTPUT_PIN) sig_w <= pwdata[3:0];
      if (paddr == rfb_pkg::ADDR_DRV) drv_w <= pwdata[1:0];
      if (paddr == rfb_pkg::ADDR_RXCTL) mfr_w <= pwdata[0];
    end
  end
  // outputs lag the registers by a few flops, judge them once settled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      quiet <= 4'h0;
    else if (wr_acc)
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end
  sequence setup_cycle;
    psel && !penable;
  endsequence
  sequence settled;
    quiet > 4'h3;
  endsequence
  chk_pready_fast: assert property (setup_cycle ##0
    paddr != rfb_pkg::ADDR_TXDATA |=> pready)
    else $error("plain access was stalled");
  chk_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response disagrees with the map");
  chk_resid_table: assert property (
    settled |-> residual_level_pct == rfb_pkg::RESID_PCT[resid_w])
    else $error("residual percent wrong");
  chk_rx_single: assert property (
    settled |-> rx_single_ended == rcv_w[0])
    else $error("single ended select wrong");
  chk_mixer_bypass: assert property (
    settled |-> mixer_bypass_to_converter == rcv_w[1])
    else $error("converter bypass wrong");
  chk_in_subcarrier: assert property (
    settled |-> decoder_subcarrier == (rcv_w[3:2] == 2'h1))
    else $error("subcarrier decode select wrong");
  chk_mfr_copy: assert property (
    settled |-> multiple_frame_receive == mfr_w)
    else $error("multiple frame receive wrong");
  chk_one_antenna: assert property (
    quiet > 4'h5 && sig_w == 4'h4 && drv_w == 2'h1 |-> !driver_envelope)
    else $error("both antennas driven");
endmodule // rfb_framer_sva
bind rfb_framer rfb_framer_sva rfb_framer_sva_inst (
  .pclk(pclk),
  .presetn(presetn),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pwdata(pwdata),
  .pready(pready),
  .pslverr(pslverr),
  .driver_envelope(driver_envelope),
  .residual_level_pct(residual_level_pct),
  .rx_single_ended(rx_single_ended),
  .mixer_bypass_to_converter(mixer_bypass_to_converter),
  .decoder_subcarrier(decoder_subcarrier),
  .multiple_frame_receive(multiple_frame_receive)
);
`default_nettype wire

// file: testbench/rfb_antenna_model.sv
`timescale 1ns/10ps
`default_nettype none
module rfb_antenna_model (
  input wire logic pclk,
  input wire logic slow,
  input wire logic demod_bit,
  input wire logic external_signal_output_pin,
  output logic external_signal_input_pin,
  output logic rx_demod_code
);
  logic [3:0] echo_reg = 4'h0;
  logic [3:0] demod_reg = 4'h0;
  // an external antenna echoes the routed pin back after a cable lag
  always_ff @(posedge pclk)
  begin
    echo_reg <= {echo_reg[2:0], external_signal_output_pin};
    demod_reg <= {demod_reg[2:0], demod_bit};
  end
  assign external_signal_input_pin = slow ? echo_reg[3] : echo_reg[0];
  assign rx_demod_code = slow ? demod_reg[3] : demod_reg[0];
endmodule // rfb_antenna_model
`default_nettype wire

// file: testbench/tb_rf_tx_bit_framer_and_signal_routing.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rf_tx_bit_framer_and_signal_routing;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sig_in;
  logic demod;
  logic sig_out;
  logic env;
  logic [4:0] amp;
  logic [6:0] pct;
  logic single;
  logic bypass;
  logic dec_in;
  logic dec_sub;
  logic mfr;
  logic busy;
  logic slow = 1'b0;
  logic demod_bit = 1'b0;
  logic [32:0] rd_q [$];
  logic [31:0] r;
  logic [4:0] cw;
  int w;
  int n1;
  int n2;
  int cycles = 0;
  int fail_count = 0;
  int checks = 0;
  always #5 pclk = ~pclk;
  rfb_framer rfb_framer_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_signal_input_pin(sig_in), .rx_demod_code(demod),
    .external_signal_output_pin(sig_out), .driver_envelope(env),
    .driver_amplitude(amp), .residual_level_pct(pct),
    .rx_single_ended(single), .mixer_bypass_to_converter(bypass),
    .decoder_input(dec_in), .decoder_subcarrier(dec_sub),
    .multiple_frame_receive(mfr), .tx_busy(busy)
  );
  rfb_antenna_model rfb_antenna_model_inst (
    .pclk(pclk), .slow(slow), .demod_bit(demod_bit),
    .external_signal_output_pin(sig_out),
    .external_signal_input_pin(sig_in), .rx_demod_code(demod)
  );
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      w++;
      @(posedge pclk);
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic send(input logic [7:0] d, input logic last,
      input logic [3:0] skip, input logic pe, input logic po,
      input logic [2:0] g, input logic pin);
    logic b [$];
    int n;
    logic p;
    n = !last ? 8 : (skip > 4'h8 ? 0 : 8 - skip);
    p = po;
    b.push_back(1'b0);
    for (int i = 0; i < n; i++)
    begin
      b.push_back(d[i]);
      p ^= d[i];
    end
    if (pe)
      b.push_back(p);
    repeat (g + 1) b.push_back(1'b0);
    b.push_back(1'b1);
    apb(1'b1, rfb_pkg::ADDR_FRAME,
      {16'h0, skip, g, 1'b0, po, pe, 1'b0, 1'b1, 4'h0});
    apb(1'b1, rfb_pkg::ADDR_TXDATA, {23'h0, last, d});
    // the start bit is low, so its falling edge marks the frame
    repeat (200)
      if ((pin ? sig_out : env) !== 1'b0)
        @(posedge pclk) #1;
    foreach (b[k])
    begin
      check(pin ? sig_out : env, b[k]);
      repeat (2) @(posedge pclk);
      #1;
    end
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
      check({pslverr, prdata}, rd_q.pop_front());
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  initial
  begin
    void'($urandom(32'ha687));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(rfb_pkg::ADDR_RCV, 33'h0);
    apb(1'b1, 8'h24, 32'hffffffff);
    rd(8'h24, {1'b1, 32'h0});
    rd(rfb_pkg::ADDR_TXDATA, 33'h0);
    for (int v = 0; v < 4; v++)
    begin
      apb(1'b1, rfb_pkg::ADDR_RCV, 32'(v));
      rd(rfb_pkg::ADDR_RCV, 33'(v));
      repeat (3) @(posedge pclk);
      check({bypass, single}, 33'(v));
    end
    for (int s = 25; s < 32; s++)
    begin
      apb(1'b1, rfb_pkg::ADDR_AMP, 32'(s));
      repeat (3) @(posedge pclk);
      check(pct, 33'(55 - 5 * (s - 25)));
    end
    apb(1'b1, rfb_pkg::ADDR_DRV, 32'h1);
    // slow bits keep the buffer full long enough to stall a push
    apb(1'b1, rfb_pkg::ADDR_TIMER, 32'h1f0302);
    apb(1'b1, rfb_pkg::ADDR_FRAME, 32'h11);
    repeat (16) apb(1'b1, rfb_pkg::ADDR_TXDATA, 32'($urandom & 8'hff));
    repeat (20) @(posedge pclk);
    check(busy, 33'h0);
    rd(rfb_pkg::ADDR_STATUS, 33'h10);
    apb(1'b1, rfb_pkg::ADDR_FRAME, 32'h10);
    apb(1'b1, rfb_pkg::ADDR_TXDATA, 32'h1a5);
    apb(1'b1, rfb_pkg::ADDR_TXDATA, 32'h05a);
    check(w != 0, 33'h1);
    r = '1;
    for (int i = 0; i < 400 && r !== 32'h0; i++)
    begin
      repeat (20) @(posedge pclk);
      apb(1'b0, rfb_pkg::ADDR_STATUS, 32'h0);
    end
    check(r, 33'h0);
    apb(1'b1, rfb_pkg::ADDR_TIMER, 32'h010302);
    send(8'($urandom), 1'b0, 4'h0, 1'b0, 1'b0, 3'h6, 1'b0);
    send(8'($urandom), 1'b0, 4'h0, 1'b1, 1'b0, 3'h0, 1'b0);
    send(8'($urandom), 1'b0, 4'h0, 1'b1, 1'b1, 3'h2, 1'b0);
    send(8'($urandom), 1'b1, 4'h3, 1'b1, 1'b0, 3'h1, 1'b0);
    send(8'($urandom), 1'b1, 4'h8, 1'b0, 1'b0, 3'h0, 1'b0);
    cw = 5'($urandom_range(26, 1));
    apb(1'b1, rfb_pkg::ADDR_AMP, {21'h0, 1'b1, cw, 5'h1b});
    apb(1'b1, rfb_pkg::ADDR_FRAME, 32'h10);
    apb(1'b1, rfb_pkg::ADDR_TXDATA, 32'hff);
    n1 = 0;
    n2 = 0;
    repeat (24)
    begin
      @(posedge pclk);
      #1;
      if (amp === 5'h00 && n2 == 0) n1 = 0;
      if (amp === cw && n2 == 0) n1++;
      if (amp === 5'h1b) n2++;
    end
    check(33'(n1), 33'h3);
    check(33'(n2), 33'h4);
    apb(1'b1, rfb_pkg::ADDR_AMP, 32'h0);
    apb(1'b1, rfb_pkg::ADDR_EXTERNAL_SIGNAL_OUTPUT_PIN, 32'(rfb_pkg::EXTERNAL_SIGNAL_OUTPUT_PIN_ENVELOPE));
    apb(1'b1, rfb_pkg::ADDR_RCV, 32'({rfb_pkg::EXTERNAL_SIGNAL_INPUT_PIN_GENERIC, 2'h0}));
    apb(1'b1, rfb_pkg::ADDR_DRV, 32'(rfb_pkg::DRV_LOW));
    repeat (12) @(posedge pclk);
    check({sig_out, dec_in, env, dec_sub}, 33'hc);
    apb(1'b1, rfb_pkg::ADDR_DRV, 32'h1);
    send(8'($urandom), 1'b0, 4'h0, 1'b0, 1'b0, 3'h0, 1'b1);
    check(env, 33'h0);
    slow <= 1'b1;
    apb(1'b1, rfb_pkg::ADDR_EXTERNAL_SIGNAL_OUTPUT_PIN, 32'(rfb_pkg::EXTERNAL_SIGNAL_OUTPUT_PIN_CODE));
    apb(1'b1, rfb_pkg::ADDR_RCV, 32'({rfb_pkg::EXTERNAL_SIGNAL_INPUT_PIN_SUBCARRIER, 2'h0}));
    apb(1'b1, rfb_pkg::ADDR_DRV, 32'(rfb_pkg::DRV_EXTERNAL));
    apb(1'b1, rfb_pkg::ADDR_RXCTL, 32'h1);
    for (int v = 1; v >= 0; v--)
    begin
      demod_bit <= v[0];
      repeat (20) @(posedge pclk);
      check({sig_out, env, dec_in, dec_sub, mfr}, {v[0], v[0], v[0], 2'h3});
    end
    wrap_up();
  end
endmodule // tb_rf_tx_bit_framer_and_signal_routing
`default_nettype wire
